// ===== hw/cpu_core_pkg.sv
/*
  Constants for the cycle sequencer, stack pointer and internal address map.
  Assumes an 8-bit core in which each i_clk cycle is one phase of a state.
*/
package cpu_core_pkg;

  // machine-cycle states, one-hot
  typedef enum logic [5:0] {
    ST_S1 = 6'b000001,
    ST_S2 = 6'b000010,
    ST_S3 = 6'b000100,
    ST_S4 = 6'b001000,
    ST_S5 = 6'b010000,
    ST_S6 = 6'b100000
  } mstate_t;

  // internal data targets, one-hot except TGT_NONE, which is all zeros
  typedef enum logic [3:0] {
    TGT_NONE  = 4'b0000,
    TGT_LOWER = 4'b0001,
    TGT_UPPER = 4'b0010,
    TGT_SFR   = 4'b0100,
    TGT_MAP   = 4'b1000
  } target_t;

  localparam int          STATES_PER_CYCLE = 6;
  localparam int          PHASES_PER_STATE = 2;
  localparam logic [7:0]  STK_RESET        = 8'h07;
  localparam logic [7:0]  B_RESET          = 8'h00;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam logic [7:0]  PWR_AUX_RESET    = 8'h00;
  localparam logic [15:0] PC_RESET         = 16'h0000;

  localparam logic [7:0]  ADDR_STK         = 8'h81;
  localparam logic [7:0]  ADDR_B           = 8'hf0;
  localparam logic [7:0]  ADDR_STATUS      = 8'hd0;
  localparam logic [7:0]  ADDR_CFG         = 8'hb1;
  localparam logic [7:0]  ADDR_PWR_AUX     = 8'h88;

  localparam int          STATUS_BANK_LO   = 3;
  localparam int          STATUS_BANK_HI   = 4;
  localparam int          CFG_MAP_BIT      = 4;

  localparam logic [15:0] INT_CODE_TOP     = 16'h1fff;
  localparam logic [7:0]  UPPER_BASE       = 8'h80;
  localparam logic [7:0]  BIT_AREA_LO      = 8'h20;
  localparam logic [7:0]  BIT_AREA_HI      = 8'h2f;

endpackage

// ===== hw/cycle_sequencer.sv
/*
  Free-running six-state, two-phase machine-cycle counter with address
  latch strobe. Assumes i_clk is the phase clock and i_ce gates all state.
*/
`timescale 1ns/1ps
module cycle_sequencer (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_ce,
  output cpu_core_pkg::mstate_t     o_state,
  output logic                      o_phase2,
  output logic                      o_ale
);
  import cpu_core_pkg::*;

  mstate_t state_q, state_d;
  logic    phase2_q, phase2_d;

  always_comb begin
    state_d  = state_q;
    phase2_d = phase2_q;
    if (i_ce) begin
      phase2_d = ~phase2_q;
      if (phase2_q) begin
        case (state_q)
          ST_S1:   state_d = ST_S2;
          ST_S2:   state_d = ST_S3;
          ST_S3:   state_d = ST_S4;
          ST_S4:   state_d = ST_S5;
          ST_S5:   state_d = ST_S6;
          default: state_d = ST_S1;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q  <= ST_S1;
      phase2_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      phase2_q <= phase2_d;
    end
  end

  assign o_state  = state_q;
  assign o_phase2 = phase2_q;
  // strobe spans state1 phase2 to state2 phase1, and state4 phase2 to state5 phase1
  assign o_ale = (phase2_q  && (state_q == ST_S1 || state_q == ST_S4)) ||
                 (!phase2_q && (state_q == ST_S2 || state_q == ST_S5));

  ////////////////////////////////////////////////////////////////////////////
  sequence s_ce12;
    i_ce [*8] ##1 i_ce [*4];
  endsequence

  AST_CYCLE_SIX_STATES: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_q == ST_S1 && !phase2_q) ##0 s_ce12 |=> (state_q == ST_S1 && !phase2_q))
    else $error("machine cycle is not twelve phases");

  AST_ALE_SPAN: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_ce && phase2_q && state_q == ST_S4) |=> (o_ale && state_q == ST_S5 && !phase2_q))
    else $error("address latch strobe does not span into state 5");

endmodule // cycle_sequencer

// ===== hw/data_addr_decoder.sv
/*
  Internal data address decoder: picks one target by addressing mode.
  Assumes the map select level comes from the configuration register.
*/
`timescale 1ns/1ps
module data_addr_decoder (
  input  wire logic                 i_valid,
  input  wire logic                 i_indirect,
  input  wire logic [7:0]           i_addr,
  input  wire logic                 i_map_sel,
  output cpu_core_pkg::target_t     o_target,
  output logic                      o_bit_addressable
);
  import cpu_core_pkg::*;

  logic upper;

  always_comb begin
    upper             = (i_addr >= UPPER_BASE);
    o_target          = TGT_NONE;
    o_bit_addressable = 1'b0;
    if (!i_valid) begin
      o_target = TGT_NONE;
    end else if (!upper) begin
      o_target          = TGT_LOWER;
      o_bit_addressable = !i_indirect &&
                          (i_addr >= BIT_AREA_LO) && (i_addr <= BIT_AREA_HI);
    end else if (i_indirect) begin
      o_target = TGT_UPPER;
    end else if (i_map_sel && i_addr == ADDR_PWR_AUX) begin
      o_target = TGT_MAP;
    end else begin
      o_target          = TGT_SFR;
      o_bit_addressable = (i_addr[2:0] == 3'h0);
    end
  end

endmodule // data_addr_decoder

// ===== hw/cpu_cycle_mem_map.sv
/*
  Core sequencing and address-space logic: fetch slots, stack pointer,
  secondary operand register, bank select, code space and data map.
  Assumes the instruction decoder drives the op strobes, one cycle each.
*/
// What this block does
// - secondary register is muldiv source, destination, scratch
// - stack pointer increments before push write
// - stack pointer decrements after pop read
// - stack pointer resets to 07h, software accessible
// - machine cycle has six states
// - each state has phase 1, phase 2
// - address strobe twice per machine cycle
// - opcode at state1 phase2, second byte at state 4
// - one-byte instruction: discarded S4 fetch, no increment
// - one-cycle execution ends at state6 phase2
// - select high: internal code up to 1FFFh
// - select low: all fetches external
// - upper 128: indirect RAM, direct registers
// - lower 128 reachable direct and indirect
// - 20h-2Fh bit area; 00h-1Fh four banks
// - one bank active, status bits 3,4
// - first two bank registers are pointers
// - external data address 16 or 8 bits
// - stack anywhere, up to 256 deep
// - mapped registers only while map bit set
// - map bit never cleared by hardware
// - direct registers at addresses xxxxx000 bit-addressable, except mapped 88h
`timescale 1ns/1ps
module cpu_cycle_mem_map (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_ce,
  input  wire logic                 i_external_code_select,
  input  wire logic [7:0]           i_code_data,
  input  wire logic                 i_two_byte,
  input  wire logic                 i_pc_load,
  input  wire logic [15:0]          i_pc_value,
  input  wire logic                 i_push,
  input  wire logic                 i_pop,
  input  wire logic                 i_muldiv_we,
  input  wire logic [7:0]           i_muldiv_b,
  input  wire logic                 i_da_valid,
  input  wire logic                 i_da_indirect,
  input  wire logic                 i_da_wr,
  input  wire logic [7:0]           i_da_addr,
  input  wire logic [7:0]           i_da_wdata,
  input  wire logic                 i_ptr_sel,
  input  wire logic                 i_xdata_wide,
  input  wire logic [15:0]          i_dptr,
  input  wire logic [7:0]           i_ptr_value,
  output cpu_core_pkg::mstate_t     o_state,
  output logic                      o_phase2,
  output logic                      o_ale,
  output logic                      o_code_fetch,
  output logic [15:0]               o_code_addr,
  output logic                      o_code_internal,
  output logic [7:0]                o_opcode,
  output logic [7:0]                o_operand,
  output logic                      o_exec_done,
  output logic [7:0]                o_stack_top_pointer,
  output logic [7:0]                o_stack_addr,
  output logic [7:0]                o_b_reg,
  output logic [1:0]                o_bank,
  output logic [7:0]                o_ptr_reg_addr,
  output logic [15:0]               o_xdata_addr,
  output cpu_core_pkg::target_t     o_da_target,
  output logic                      o_da_bit_addressable,
  output logic [7:0]                o_da_rdata,
  output logic                      o_sfr_map_select
);
  import cpu_core_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and address decode

  mstate_t state;
  logic    phase2;
  target_t target;
  logic    map_sel;

  cycle_sequencer u_seq (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_ce     (i_ce),
    .o_state  (state),
    .o_phase2 (phase2),
    .o_ale    (o_ale)
  );

  data_addr_decoder u_dec (
    .i_valid           (i_da_valid),
    .i_indirect        (i_da_indirect),
    .i_addr            (i_da_addr),
    .i_map_sel         (map_sel),
    .o_target          (target),
    .o_bit_addressable (o_da_bit_addressable)
  );

  logic st1_ph2;
  logic st4_ph2;
  logic st6_ph2;
  assign st1_ph2 = i_ce && phase2 && (state == ST_S1);
  assign st4_ph2 = i_ce && phase2 && (state == ST_S4);
  assign st6_ph2 = i_ce && phase2 && (state == ST_S6);

  ////////////////////////////////////////////////////////////////////////////
  // fetch and program counter

  logic [15:0] pc_q, pc_d;
  logic [7:0]  ir_q, ir_d;
  logic [7:0]  opnd_q, opnd_d;
  logic        done_q, done_d;

  always_comb begin
    pc_d   = pc_q;
    ir_d   = ir_q;
    opnd_d = opnd_q;
    done_d = done_q;
    // pulse is held, not cleared, while the enable is low
    if (i_ce) begin
      done_d = st6_ph2;
    end
    if (st1_ph2) begin
      ir_d = i_code_data;
      pc_d = pc_q + 16'h0001;
    end
    if (st4_ph2) begin
      if (i_two_byte) begin
        opnd_d = i_code_data;
        pc_d   = pc_q + 16'h0001;
      end
      // one-byte form: byte read here is dropped, counter held
    end
    if (i_ce && i_pc_load) begin
      pc_d = i_pc_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pc_q   <= PC_RESET;
      ir_q   <= 8'h00;
      opnd_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      pc_q   <= pc_d;
      ir_q   <= ir_d;
      opnd_q <= opnd_d;
      done_q <= done_d;
    end
  end

  // fetch strobe marks both code reads, including the discarded one
  assign o_code_fetch = phase2 && (state == ST_S1 || state == ST_S4);
  assign o_code_addr  = pc_q;
  assign o_code_internal = i_external_code_select && (pc_q <= INT_CODE_TOP);
  assign o_opcode     = ir_q;
  assign o_operand    = opnd_q;
  assign o_exec_done  = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // register file: stack pointer, secondary register, status, config

  logic [7:0] stk_q, stk_d;
  logic [7:0] b_q, b_d;
  logic [7:0] status_q, status_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] pwr_aux_q, pwr_aux_d;
  logic       sfr_wr;
  logic       map_wr;

  assign sfr_wr = i_ce && i_da_wr && (target == TGT_SFR);
  assign map_wr = i_ce && i_da_wr && (target == TGT_MAP);

  always_comb begin
    stk_d     = stk_q;
    b_d       = b_q;
    status_d  = status_q;
    cfg_d     = cfg_q;
    pwr_aux_d = pwr_aux_q;
    if (sfr_wr && i_da_addr == ADDR_STK) begin
      stk_d = i_da_wdata;
    end
    // stack motion wins over a software write in the same cycle
    if (i_ce && i_push) begin
      stk_d = stk_q + 8'h01;
    end else if (i_ce && i_pop) begin
      stk_d = stk_q - 8'h01;
    end
    if (sfr_wr && i_da_addr == ADDR_B) begin
      b_d = i_da_wdata;
    end
    if (i_ce && i_muldiv_we) begin
      b_d = i_muldiv_b;
    end
    if (sfr_wr && i_da_addr == ADDR_STATUS) begin
      status_d = i_da_wdata;
    end
    if (sfr_wr && i_da_addr == ADDR_CFG) begin
      cfg_d = i_da_wdata;
    end
    if (map_wr) begin
      pwr_aux_d = i_da_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stk_q     <= STK_RESET;
      b_q       <= B_RESET;
      status_q  <= STATUS_RESET;
      cfg_q     <= CFG_RESET;
      pwr_aux_q <= PWR_AUX_RESET;
    end else begin
      stk_q     <= stk_d;
      b_q       <= b_d;
      status_q  <= status_d;
      cfg_q     <= cfg_d;
      pwr_aux_q <= pwr_aux_d;
    end
  end

  assign map_sel = cfg_q[CFG_MAP_BIT];

  // push writes at the incremented slot, pop reads the current top
  assign o_stack_addr        = i_push ? (stk_q + 8'h01) : stk_q;
  assign o_stack_top_pointer = stk_q;
  assign o_b_reg             = b_q;
  assign o_sfr_map_select    = map_sel;
  assign o_bank              = {status_q[STATUS_BANK_HI], status_q[STATUS_BANK_LO]};
  assign o_ptr_reg_addr      = {3'h0, o_bank, 2'h0, i_ptr_sel};
  assign o_xdata_addr        = i_xdata_wide ? i_dptr : {8'h00, i_ptr_value};
  assign o_da_target         = target;

  // read side; RAM targets are answered by the memories themselves
  always_comb begin
    o_da_rdata = 8'h00;
    if (target == TGT_MAP) begin
      o_da_rdata = pwr_aux_q;
    end else if (target != TGT_SFR) begin
      o_da_rdata = 8'h00;
    end else if (i_da_addr == ADDR_STK) begin
      o_da_rdata = stk_q;
    end else if (i_da_addr == ADDR_B) begin
      o_da_rdata = b_q;
    end else if (i_da_addr == ADDR_STATUS) begin
      o_da_rdata = status_q;
    end else if (i_da_addr == ADDR_CFG) begin
      o_da_rdata = cfg_q;
    end
  end

  assign o_state  = state;
  assign o_phase2 = phase2;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_push_seen;
    i_ce && i_push && !i_srst;
  endsequence

  AST_PUSH_PREINC: assert property (@(posedge i_clk) disable iff (i_srst)
    s_push_seen |-> (o_stack_addr == stk_q + 8'h01) ##1 (stk_q == $past(stk_q) + 8'h01))
    else $error("push did not pre-increment stack pointer");

  AST_POP_POSTDEC: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_ce && i_pop && !i_push) |-> (o_stack_addr == stk_q) ##1 (stk_q == $past(stk_q) - 8'h01))
    else $error("pop did not post-decrement stack pointer");

  AST_STK_RESET: assert property (@(posedge i_clk)
    $past(i_srst) |-> (stk_q == STK_RESET))
    else $error("stack pointer not 07h after reset");

  AST_EXEC_DONE: assert property (@(posedge i_clk) disable iff (i_srst)
    st6_ph2 |=> o_exec_done ##1 (!o_exec_done || !$past(i_ce)))
    else $error("execution end not flagged after state 6 phase 2");

  AST_DISCARD_FETCH: assert property (@(posedge i_clk) disable iff (i_srst)
    (st4_ph2 && !i_two_byte && !i_pc_load) |=> ($stable(pc_q) && $stable(opnd_q)))
    else $error("discarded fetch changed counter or operand");

  AST_CODE_SPACE: assert property (@(posedge i_clk) disable iff (i_srst)
    o_code_internal |-> (i_external_code_select && pc_q < 16'h2000))
    else $error("internal code selected out of range");

  AST_MAP_GATE: assert property (@(posedge i_clk) disable iff (i_srst)
    (target == TGT_MAP) |-> (map_sel && !i_da_indirect && i_da_addr == ADDR_PWR_AUX))
    else $error("mapped area reached without map select");

  AST_MAP_STICKY: assert property (@(posedge i_clk) disable iff (i_srst)
    (map_sel && !(sfr_wr && i_da_addr == ADDR_CFG)) |=> map_sel)
    else $error("map select cleared without a write");

  AST_ONE_TARGET: assert property (@(posedge i_clk) disable iff (i_srst)
    i_da_valid |-> $onehot(target))
    else $error("data address decoded to not exactly one target");

  AST_PTR_BANK: assert property (@(posedge i_clk) disable iff (i_srst)
    o_ptr_reg_addr == {3'h0, status_q[4], status_q[3], 2'h0, i_ptr_sel})
    else $error("pointer register not in active bank");

endmodule // cpu_cycle_mem_map

// ===== tb/ext_code_mem.sv
/*
  Behavioural external program memory answering code fetches.
  Assumes the core shows fetch strobe and address combinationally.
*/
`timescale 1ns/1ps
module ext_code_mem (
  input  wire logic        i_clk,
  input  wire logic        i_fetch,
  input  wire logic [15:0] i_addr,
  output logic      [7:0]  o_data
);
  logic [7:0] last_q;
  // released bus shows the inverse of the last byte, never a stale copy
  always_comb begin
    if (i_fetch) o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'h3c;
    else o_data = ~last_q;
  end
  always_ff @(posedge i_clk) begin
    if (i_fetch) last_q <= o_data;
  end
endmodule // ext_code_mem

// ===== tb/tb.sv
/*
  Self-checking bench: phase walk, fetch slots, code space, stack and data map.
  Assumes the core plus an external code memory model on one 100 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  import cpu_core_pkg::*;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_external_code_select = 1'b1;
  logic        i_two_byte = 1'b0, i_pc_load = 1'b0, i_push = 1'b0, i_pop = 1'b0;
  logic        i_muldiv_we = 1'b0, i_da_valid = 1'b0, i_da_indirect = 1'b0, i_da_wr = 1'b0;
  logic        i_ptr_sel = 1'b0, i_xdata_wide = 1'b0;
  logic [7:0]  i_code_data, i_muldiv_b = 8'h00, i_da_addr = 8'h00, i_da_wdata = 8'h00;
  logic [7:0]  i_ptr_value = 8'h00;
  logic [15:0] i_pc_value = 16'h0000, i_dptr = 16'h0000;
  mstate_t     o_state;
  target_t     o_da_target;
  logic        o_phase2, o_ale, o_code_fetch, o_code_internal, o_exec_done;
  logic        o_da_bit_addressable, o_sfr_map_select;
  logic [7:0]  o_opcode, o_operand, o_stack_top_pointer, o_stack_addr, o_b_reg;
  logic [7:0]  o_ptr_reg_addr, o_da_rdata;
  logic [1:0]  o_bank;
  logic [15:0] o_code_addr, o_xdata_addr;
  logic [15:0] lf = 16'h002e, pc_e;
  logic [15:0] cs [4] = '{16'h1fff, 16'h2000, 16'h0000, 16'hffff};
  logic [7:0]  op_e, opd_e, stk_e, a;
  logic [1:0]  bank_e = 2'h0;
  logic        opd_set = 1'b0, m;
  int          n_mismatch = 0, checked = 0;

  always #5 i_clk = ~i_clk;

  cpu_cycle_mem_map dut_u (
    .i_clk, .i_srst, .i_ce, .i_external_code_select, .i_code_data, .i_two_byte,
    .i_pc_load, .i_pc_value, .i_push, .i_pop, .i_muldiv_we, .i_muldiv_b, .i_da_valid,
    .i_da_indirect, .i_da_wr, .i_da_addr, .i_da_wdata, .i_ptr_sel, .i_xdata_wide,
    .i_dptr, .i_ptr_value, .o_state, .o_phase2, .o_ale, .o_code_fetch, .o_code_addr,
    .o_code_internal, .o_opcode, .o_operand, .o_exec_done, .o_stack_top_pointer,
    .o_stack_addr, .o_b_reg, .o_bank, .o_ptr_reg_addr, .o_xdata_addr, .o_da_target,
    .o_da_bit_addressable, .o_da_rdata, .o_sfr_map_select
  );
  ext_code_mem mem_u (.i_clk, .i_fetch(o_code_fetch), .i_addr(o_code_addr), .o_data(i_code_data));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] mf(logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [3:0] tgt(logic ind, logic [7:0] ad, logic mp);
    if (ad < 8'h80) return 4'h1;
    if (ind) return 4'h2;
    if (mp && ad == ADDR_PWR_AUX) return 4'h8;
    return 4'h4;
  endfunction
  function automatic logic bitx(logic ind, logic [7:0] ad, logic mp);
    if (ind) return 1'b0;
    if (ad >= 8'h20 && ad <= 8'h2f) return 1'b1;
    return ad >= 8'h80 && ad[2:0] == 3'h0 && !(mp && ad == ADDR_PWR_AUX);
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one data access per cycle; pointer and external address inputs ride along at random
  task automatic da(input logic ind, input logic wr, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge i_clk);
    i_da_valid <= 1'b1;
    i_da_indirect <= ind;
    i_da_wr <= wr;
    i_da_addr <= ad;
    i_da_wdata <= wd;
    i_ptr_sel <= lf[2];
    i_xdata_wide <= lf[3];
    i_dptr <= lf ^ 16'h5a5a;
    i_ptr_value <= lf[11:4];
    lf = nx(lf);
    #1;
    chk("ptr_reg", o_ptr_reg_addr, {3'h0, bank_e, 2'h0, i_ptr_sel});
    chk("xdata", o_xdata_addr, i_xdata_wide ? i_dptr : {8'h00, i_ptr_value});
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    pc_e = 16'h0000;
    for (int k = 0; k < 36; k++) begin
      #1;
      chk("state", o_state, 6'h01 << ((k % 12) / 2));
      chk("phase", o_phase2, k % 2);
      chk("ale", o_ale, (k % 12) inside {1, 2, 7, 8});
      chk("fetch", o_code_fetch, (k % 12) inside {1, 7});
      chk("done", o_exec_done, k > 0 && k % 12 == 0);
      chk("pc", o_code_addr, pc_e);
      if (k == 0) begin
        chk("stk_rst", o_stack_top_pointer, STK_RESET);
        chk("b_rst", o_b_reg, B_RESET);
        chk("bank_rst", o_bank, 2'h0);
        chk("map_rst", o_sfr_map_select, 1'b0);
      end
      if (k % 12 == 2) chk("opcode", o_opcode, op_e);
      if (k % 12 == 8 && opd_set) chk("operand", o_operand, opd_e);
      if (k % 12 == 1) begin
        op_e = mf(pc_e);
        pc_e++;
      end
      if (k % 12 == 7 && i_two_byte) begin
        opd_e = mf(pc_e);
        pc_e++;
        opd_set = 1'b1;
      end
      @(posedge i_clk);
      i_two_byte <= lf[0];
      lf = nx(lf);
    end
    // a stalled clock enable must freeze the phase counter and fetch address
    i_ce <= 1'b0;
    #1;
    a = {2'h0, o_state};
    m = o_phase2;
    pc_e = o_code_addr;
    repeat (3) @(posedge i_clk);
    #1;
    chk("freeze_state", o_state, a);
    chk("freeze_phase", o_phase2, m);
    chk("freeze_pc", o_code_addr, pc_e);
    chk("freeze_done", o_exec_done, 1'b1);
    @(posedge i_clk);
    i_ce <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      m = (j < 4);
      @(posedge i_clk);
      i_pc_load <= 1'b1;
      i_pc_value <= cs[j % 4];
      i_external_code_select <= m;
      @(posedge i_clk);
      i_pc_load <= 1'b0;
      #1;
      chk("pc_load", o_code_addr, cs[j % 4]);
      chk("code_int", o_code_internal, m && cs[j % 4] <= INT_CODE_TOP);
    end
    da(1'b0, 1'b1, ADDR_STK, 8'hff);
    stk_e = 8'hff;
    for (int j = 0; j < 24; j++) begin
      @(posedge i_clk);
      i_da_valid <= 1'b0;
      i_da_wr <= 1'b0;
      i_push <= (j == 0) | lf[0];
      i_pop <= lf[1];
      lf = nx(lf);
      #1;
      chk("stk", o_stack_top_pointer, stk_e);
      chk("stack_addr", o_stack_addr, i_push ? 8'(stk_e + 8'h01) : stk_e);
      if (i_push) stk_e++;
      else if (i_pop) stk_e--;
    end
    @(posedge i_clk);
    i_push <= 1'b0;
    i_pop <= 1'b0;
    da(1'b0, 1'b0, ADDR_STK, 8'h00);
    chk("stk_rd", o_da_rdata, stk_e);
    da(1'b0, 1'b1, ADDR_B, 8'h77);
    da(1'b0, 1'b0, ADDR_B, 8'h00);
    chk("b_rd", o_da_rdata, 8'h77);
    // multiply result must beat a software write in the same cycle
    @(posedge i_clk);
    i_muldiv_we <= 1'b1;
    i_muldiv_b <= 8'h3e;
    i_da_wr <= 1'b1;
    @(posedge i_clk);
    i_muldiv_we <= 1'b0;
    i_da_wr <= 1'b0;
    #1;
    chk("b_muldiv", o_b_reg, 8'h3e);
    for (int b = 0; b < 4; b++) begin
      da(1'b0, 1'b1, ADDR_STATUS, 8'(b << 3));
      bank_e = 2'(b);
      da(1'b0, 1'b0, ADDR_STATUS, 8'h00);
      chk("bank", o_bank, bank_e);
      chk("status_rd", o_da_rdata, 8'(b << 3));
    end
    for (int p = 0; p < 2; p++) begin
      m = p[0];
      da(1'b0, 1'b1, ADDR_PWR_AUX, 8'h5a);
      da(1'b0, 1'b1, ADDR_CFG, {3'h0, m, 4'h0});
      da(1'b0, 1'b0, ADDR_PWR_AUX, 8'h00);
      chk("aux_rst", o_da_rdata, 8'h00);
      da(1'b0, 1'b1, ADDR_PWR_AUX, 8'ha5);
      da(1'b0, 1'b0, ADDR_PWR_AUX, 8'h00);
      chk("aux_rd", o_da_rdata, m ? 8'ha5 : 8'h00);
      da(1'b0, 1'b0, ADDR_CFG, 8'h00);
      chk("cfg_rd", o_da_rdata, {3'h0, m, 4'h0});
      for (int j = 0; j < 40; j++) begin
        a = (j == 0) ? ADDR_PWR_AUX : lf[15:8];
        da(j > 0 && lf[1], 1'b0, a, 8'h00);
        chk("target", o_da_target, tgt(i_da_indirect, a, m));
        chk("bitaddr", o_da_bit_addressable, bitx(i_da_indirect, a, m));
        chk("map_hold", o_sfr_map_select, m);
      end
    end
    @(posedge i_clk);
    i_da_valid <= 1'b0;
    #1;
    chk("no_target", o_da_target, 4'h0);
    // reset again in mid-run: pointer, map bit and state must restart
    @(posedge i_clk);
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk("stk_rst2", o_stack_top_pointer, STK_RESET);
    chk("map_rst2", o_sfr_map_select, 1'b0);
    chk("state_rst2", o_state, 6'h01);
    test_done();
  end
endmodule // tb
